/* inc/iocc_pkg.sv */
// Overview of operation
// - single-unit number: bits 8-10 zero, 11-15 device
// - multiunit: bit 8 one, controller, then device
// - even register address, odd flags plus count
// - memory or device parity fault sets error flag
// - zero count, no chaining: signal count done
// - zero count, chaining: fetch and load next doubleword
// - completion puts status in bits 0-7, rest zero
// - status captured only on channel or unusual end
// - unusual end terminates always, ignores chaining
// - interrupt flag: request on zero count or end
// - zero count means maximum, wraps to all ones
// - status bits 5-7 always loaded as zero
// - channel end meaningless when unusual end set
// - chained doubleword bytes not counted
package iocc_pkg;
    localparam int WORD_W        = 16;
    localparam int COUNT_W       = 13;
    // odd register field positions, bit 0 of the manual is msb
    localparam int ERR_POS       = 15;
    localparam int CHAIN_POS     = 14;
    localparam int IRQ_POS       = 13;
    // status byte positions inside the byte, msb first
    localparam int ST_TE_POS     = 7;
    localparam int ST_WL_POS     = 6;
    localparam int ST_CM_POS     = 5;
    localparam int ST_CE_POS     = 4;
    localparam int ST_UE_POS     = 3;
    localparam logic [7:0]  STATUS_MASK   = 8'hF8;
    localparam logic [15:0] WORD_RESET    = 16'h0000;
    localparam logic [15:0] FLAGS_RESET   = 16'h0000;
    localparam logic [12:0] COUNT_ONE     = 13'h0001;
    localparam logic [15:0] ADDR_STEP     = 16'h0001;
    localparam logic [15:0] FETCH_STEP    = 16'h0002;
    // device number layout inside the 8-bit number
    localparam logic [2:0]  SINGLE_TAG    = 3'h0;
    localparam int SINGLE_DEV_W  = 5;
    localparam int MULTI_CTL_W   = 3;
    localparam int MULTI_DEV_W   = 4;

    typedef enum logic [2:0] {
        IOCC_IDLE,
        IOCC_ACTIVE,
        IOCC_FETCH_HI,
        IOCC_FETCH_LO,
        IOCC_WAIT_END
    } iocc_state_e;
endpackage : iocc_pkg

/* logic/iocc_channel.sv */
`timescale 1ns/100ps
module iocc_channel (
    // system
    input  wire logic                          clock,
    input  wire logic                          reset_n,
    // cpu direct read and write access to the register pair, plus start and busy
    input  wire logic                          reg_write,
    input  wire logic                          reg_read,
    input  wire logic                          reg_odd,
    input  wire logic [iocc_pkg::WORD_W-1:0]   reg_wdata,
    output logic      [iocc_pkg::WORD_W-1:0]   reg_rdata,
    input  wire logic                          start,
    output logic                               busy,
    // device number decode
    input  wire logic [7:0]                    device_number,
    output logic                               dev_num_valid,
    output logic                               dev_num_multi,
    output logic [iocc_pkg::MULTI_CTL_W-1:0]   dev_ctl_id,
    output logic [iocc_pkg::SINGLE_DEV_W-1:0]  dev_unit_id,
    // device controller side
    input  wire logic                          byte_done,
    input  wire logic                          byte_parity_err,
    input  wire logic                          mem_fault,
    input  wire logic                          channel_end,
    input  wire logic                          unusual_end,
    input  wire logic [7:0]                    status_byte,
    output logic                               count_done,
    output logic                               irq_request,
    output logic [iocc_pkg::WORD_W-1:0]        byte_word_addr,
    output logic                               byte_lane,
    // chained doubleword fetch
    output logic                               fetch_req,
    output logic [iocc_pkg::WORD_W-1:0]        fetch_addr,
    input  wire logic                          fetch_ack,
    input  wire logic                          fetch_fault,
    input  wire logic [iocc_pkg::WORD_W-1:0]   fetch_data
);
    import iocc_pkg::*;

    iocc_state_e          state_reg;
    iocc_state_e          state_next;
    logic [WORD_W-1:0]    addr_reg;
    logic [WORD_W-1:0]    addr_next;
    logic                 err_reg;
    logic                 err_next;
    logic                 chain_reg;
    logic                 chain_next;
    logic                 irqf_reg;
    logic                 irqf_next;
    logic [COUNT_W-1:0]   count_reg;
    logic [COUNT_W-1:0]   count_next;
    logic                 lane_reg;
    logic                 lane_next;
    logic [WORD_W-1:0]    hold_reg;
    logic [WORD_W-1:0]    hold_next;
    logic                 cdone_reg;
    logic                 cdone_next;
    logic                 irq_reg;
    logic                 irq_next;
    logic                 busy_reg;
    logic                 freq_reg;
    logic                 freq_next;
    logic [WORD_W-1:0]    faddr_reg;
    logic [WORD_W-1:0]    faddr_next;
    logic [WORD_W-1:0]    rdata_reg;
    logic                 dvalid_reg;
    logic                 dmulti_reg;
    logic [MULTI_CTL_W-1:0]  dctl_reg;
    logic [SINGLE_DEV_W-1:0] dunit_reg;

    // device number decode
    wire       num_single = (device_number[7:5] == SINGLE_TAG);
    wire       num_multi  = device_number[7];
    wire [MULTI_CTL_W-1:0]  num_ctl  = num_multi ? device_number[6:4] : '0;
    wire [SINGLE_DEV_W-1:0] num_unit = num_multi ? {1'b0, device_number[3:0]}
                                                 : device_number[4:0];

    // odd register image and read mux
    wire [WORD_W-1:0] odd_image = {err_reg, chain_reg, irqf_reg, count_reg};
    wire [WORD_W-1:0] rd_mux    = reg_odd ? odd_image : addr_reg;

    // event decode
    wire active      = (state_reg != IOCC_IDLE);
    // busy is registered from the next state so the port comes off a flop
    wire busy_next   = (state_next != IOCC_IDLE);
    wire cpu_load    = reg_write && !active;
    wire any_end     = active && (channel_end || unusual_end);
    wire take_byte   = (state_reg == IOCC_ACTIVE) && byte_done && !any_end;
    wire fault_now   = (take_byte && (mem_fault || byte_parity_err))
                       || (freq_reg && fetch_ack && fetch_fault);
    // zero start value decrements to all ones, giving the full range
    wire [COUNT_W-1:0] count_dec = count_reg - COUNT_ONE;
    wire count_zero  = take_byte && (count_dec == '0);
    wire chain_go    = count_zero && chain_reg;
    // the next doubleword sits on the first whole word after the data
    // a half-used word is skipped as well, so both lanes step one word
    wire [WORD_W-1:0] addr_after = addr_reg + ADDR_STEP;
    // unusual end forces channel end low so software never reads a stale one
    wire [7:0] status_clean = unusual_end ? (status_byte & STATUS_MASK & ~(8'h01 << ST_CE_POS))
                                          : (status_byte & STATUS_MASK);
    wire [WORD_W-1:0] status_word = {status_clean, 8'h00};
    wire irq_event   = irqf_reg && (count_zero || any_end);

    always_comb begin
        state_next = state_reg;
        addr_next  = addr_reg;
        err_next   = err_reg;
        chain_next = chain_reg;
        irqf_next  = irqf_reg;
        count_next = count_reg;
        lane_next  = lane_reg;
        hold_next  = hold_reg;
        cdone_next = cdone_reg;
        freq_next  = freq_reg;
        faddr_next = faddr_reg;
        irq_next   = irq_event;
        if (cpu_load) begin
            if (reg_odd) begin
                {err_next, chain_next, irqf_next, count_next} = reg_wdata;
            end else begin
                addr_next = reg_wdata;
                lane_next = 1'b0;
            end
        end
        unique case (state_reg)
            IOCC_IDLE: begin
                if (start && !reg_write) begin
                    state_next = IOCC_ACTIVE;
                    cdone_next = 1'b0;
                end
            end
            IOCC_ACTIVE: begin
                if (take_byte) begin
                    count_next = count_dec;
                    lane_next  = ~lane_reg;
                    if (lane_reg) begin
                        addr_next = addr_reg + ADDR_STEP;
                    end
                    if (count_zero && chain_reg) begin
                        state_next = IOCC_FETCH_HI;
                        freq_next  = 1'b1;
                        faddr_next = addr_after;
                    end else if (count_zero) begin
                        state_next = IOCC_WAIT_END;
                        cdone_next = 1'b1;
                    end
                end
            end
            IOCC_FETCH_HI: begin
                if (fetch_ack) begin
                    hold_next  = fetch_data;
                    faddr_next = faddr_reg + ADDR_STEP;
                    state_next = IOCC_FETCH_LO;
                end
            end
            IOCC_FETCH_LO: begin
                if (fetch_ack) begin
                    // error flag is kept sticky across the chain
                    addr_next  = hold_reg;
                    chain_next = fetch_data[CHAIN_POS];
                    irqf_next  = fetch_data[IRQ_POS];
                    count_next = fetch_data[COUNT_W-1:0];
                    lane_next  = 1'b0;
                    freq_next  = 1'b0;
                    state_next = IOCC_ACTIVE;
                end
            end
            IOCC_WAIT_END: begin
                cdone_next = 1'b1;
            end
        endcase
        if (fault_now) begin
            err_next = 1'b1;
        end
        if (any_end) begin
            // unusual end abandons any chain fetch in flight
            addr_next  = status_word;
            freq_next  = 1'b0;
            cdone_next = 1'b0;
            lane_next  = 1'b0;
            state_next = IOCC_IDLE;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= IOCC_IDLE;
            addr_reg  <= WORD_RESET;
            err_reg   <= FLAGS_RESET[ERR_POS];
            chain_reg <= FLAGS_RESET[CHAIN_POS];
            irqf_reg  <= FLAGS_RESET[IRQ_POS];
            count_reg <= FLAGS_RESET[COUNT_W-1:0];
            lane_reg  <= 1'b0;
            hold_reg  <= WORD_RESET;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            addr_reg  <= addr_next;
            err_reg   <= err_next;
            chain_reg <= chain_next;
            irqf_reg  <= irqf_next;
            count_reg <= count_next;
            lane_reg  <= lane_next;
            hold_reg  <= hold_next;
            busy_reg  <= busy_next;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cdone_reg <= 1'b0;
            irq_reg   <= 1'b0;
            freq_reg  <= 1'b0;
            faddr_reg <= WORD_RESET;
        end else begin
            cdone_reg <= cdone_next;
            irq_reg   <= irq_next;
            freq_reg  <= freq_next;
            faddr_reg <= faddr_next;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg  <= WORD_RESET;
            dvalid_reg <= 1'b0;
            dmulti_reg <= 1'b0;
            dctl_reg   <= '0;
            dunit_reg  <= '0;
        end else begin
            if (reg_read) begin
                rdata_reg <= rd_mux;
            end
            dvalid_reg <= num_single || num_multi;
            dmulti_reg <= num_multi;
            dctl_reg   <= num_ctl;
            dunit_reg  <= num_unit;
        end
    end

    assign reg_rdata      = rdata_reg;
    assign busy           = busy_reg;
    assign dev_num_valid  = dvalid_reg;
    assign dev_num_multi  = dmulti_reg;
    assign dev_ctl_id     = dctl_reg;
    assign dev_unit_id    = dunit_reg;
    assign count_done     = cdone_reg;
    assign irq_request    = irq_reg;
    assign byte_word_addr = addr_reg;
    assign byte_lane      = lane_reg;
    assign fetch_req      = freq_reg;
    assign fetch_addr     = faddr_reg;
endmodule : iocc_channel

/* verification/iocc_channel_props.sv */
`timescale 1ns/100ps
module iocc_channel_props (
    // clock and reset
    input wire logic        clock,
    input wire logic        reset_n,
    // register bus
    input wire logic        reg_read,
    input wire logic        reg_odd,
    input wire logic [15:0] reg_rdata,
    input wire logic        busy,
    // device number decode
    input wire logic [7:0]  device_number,
    input wire logic        dev_num_valid,
    input wire logic        dev_num_multi,
    input wire logic [2:0]  dev_ctl_id,
    input wire logic [4:0]  dev_unit_id,
    // device controller side
    input wire logic        channel_end,
    input wire logic        unusual_end,
    input wire logic        count_done,
    input wire logic        fetch_req,
    input wire logic        fetch_ack
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    wire end_ev = channel_end || unusual_end;
    chk_dev_single: assert property (device_number[7:5] == 3'h0 |=> dev_num_valid && !dev_num_multi
        && dev_unit_id == $past(device_number[4:0])) else $error("single device number decoded wrongly");
    chk_dev_multi: assert property (device_number[7] |=> dev_num_valid && dev_num_multi
        && dev_ctl_id == $past(device_number[6:4]) && dev_unit_id == {1'b0, $past(device_number[3:0])})
        else $error("multiunit device number decoded wrongly");
    chk_dev_reserved: assert property (!device_number[7] && device_number[6:5] != 2'h0 |=> !dev_num_valid)
        else $error("reserved device number marked valid");
    chk_fetch_hold: assert property (fetch_req && !fetch_ack && !end_ev |=> fetch_req)
        else $error("fetch request dropped before its word came");
    chk_count_hold: assert property (count_done && !end_ev |=> count_done)
        else $error("count done dropped before the end");
    chk_end_idle: assert property (busy && end_ev |=> !busy && !count_done && !fetch_req)
        else $error("channel still running after an end");
    chk_idle_quiet: assert property (!busy |-> !count_done && !fetch_req)
        else $error("count done or fetch while idle");
    chk_status_low: assert property (busy && end_ev ##[1:3] (reg_read && !reg_odd && !busy) |=>
        reg_rdata[10:0] == 11'h000) else $error("status word low part not zero");
endmodule : iocc_channel_props
bind iocc_channel iocc_channel_props iocc_channel_props_inst (.clock(clock), .reset_n(reset_n),
    .reg_read(reg_read), .reg_odd(reg_odd), .busy(busy), .channel_end(channel_end), .unusual_end(unusual_end),
    .dev_num_valid(dev_num_valid), .dev_num_multi(dev_num_multi), .count_done(count_done),
    .fetch_req(fetch_req), .fetch_ack(fetch_ack), .reg_rdata(reg_rdata), .device_number(device_number),
    .dev_ctl_id(dev_ctl_id), .dev_unit_id(dev_unit_id));

/* verification/iocc_dev_model.sv */
`timescale 1ns/100ps
module iocc_dev_model (
    // clock and chained fetch
    input  wire logic   clock,
    input  wire logic   fetch_req,
    output logic        fetch_ack,
    output logic        fetch_fault,
    output logic [15:0] fetch_data,
    // byte and end events
    output logic        byte_done,
    output logic        byte_parity_err,
    output logic        mem_fault,
    output logic        channel_end,
    output logic        unusual_end,
    output logic [7:0]  status_byte
);
    logic [15:0] chain_words [2];
    int          fetch_delay, wait_cnt, idx;
    initial begin
        {fetch_ack, fetch_fault, byte_done, byte_parity_err, mem_fault, channel_end, unusual_end} = 7'h00;
        {fetch_data, status_byte} = 24'h000000;
    end
    // data line scrambled whenever no word is offered
    always @(negedge clock) begin
        fetch_ack <= 1'b0;
        fetch_data <= ~fetch_data;
        if (!fetch_req) begin
            idx <= 0;
            wait_cnt <= 0;
        end else if (idx < 2 && !fetch_ack && wait_cnt < fetch_delay) begin
            wait_cnt <= wait_cnt + 1;
        end else if (idx < 2 && !fetch_ack) begin
            {fetch_ack, fetch_data} <= {1'b1, chain_words[idx]};
            idx <= idx + 1;
            wait_cnt <= 0;
        end
    end
    task automatic send_byte(input logic perr, input logic mfault);
        @(negedge clock);
        {byte_done, byte_parity_err, mem_fault} = {1'b1, perr, mfault};
        @(negedge clock);
        {byte_done, byte_parity_err, mem_fault} = 3'h0;
    endtask : send_byte
    // an end may come at any point of a table
    task automatic end_op(input logic abnormal, input logic [7:0] st);
        @(negedge clock);
        {channel_end, unusual_end, status_byte} = {!abnormal, abnormal, st};
        @(negedge clock);
        {channel_end, unusual_end, status_byte} = {2'h0, ~st};
    endtask : end_op
endmodule : iocc_dev_model

/* verification/tb_io_channel_control_chaining.sv */
`timescale 1ns/100ps
module tb_io_channel_control_chaining;
    logic        clock, reset_n, reg_write, reg_read, reg_odd, start, busy, dev_num_valid, dev_num_multi;
    logic        byte_done, byte_parity_err, mem_fault, channel_end, unusual_end, count_done, irq_request;
    logic        byte_lane, fetch_req, fetch_ack, fetch_fault;
    logic [15:0] reg_wdata, reg_rdata, byte_word_addr, fetch_addr, fetch_data;
    logic [7:0]  device_number, status_byte;
    logic [2:0]  dev_ctl_id;
    logic [4:0]  dev_unit_id;
    int          err_total, checked, irq_seen;
    iocc_channel iocc_channel_inst (.clock(clock), .reset_n(reset_n), .reg_write(reg_write), .reg_read(reg_read),
        .reg_odd(reg_odd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .start(start), .busy(busy),
        .device_number(device_number), .dev_num_valid(dev_num_valid), .dev_num_multi(dev_num_multi),
        .dev_ctl_id(dev_ctl_id), .dev_unit_id(dev_unit_id), .byte_done(byte_done), .byte_parity_err(byte_parity_err),
        .mem_fault(mem_fault), .channel_end(channel_end), .unusual_end(unusual_end), .status_byte(status_byte),
        .count_done(count_done), .irq_request(irq_request), .byte_word_addr(byte_word_addr), .byte_lane(byte_lane),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_ack(fetch_ack), .fetch_fault(fetch_fault),
        .fetch_data(fetch_data));
    iocc_dev_model iocc_dev_model_inst (.clock(clock), .fetch_req(fetch_req), .fetch_ack(fetch_ack),
        .fetch_fault(fetch_fault), .fetch_data(fetch_data), .byte_done(byte_done), .byte_parity_err(byte_parity_err),
        .mem_fault(mem_fault), .channel_end(channel_end), .unusual_end(unusual_end), .status_byte(status_byte));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) if (irq_request === 1'b1) irq_seen++;
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checked++;
        if (seen !== want) begin
            err_total++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask : check
    task automatic final_report();
        if (err_total == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report
    // one-cycle write or start strobe, then a free cycle
    task automatic pulse(input logic w, input logic s, input logic odd, input logic [15:0] d);
        @(negedge clock);
        {reg_write, start, reg_odd, reg_wdata} = {w, s, odd, d};
        @(negedge clock);
        {reg_write, start} = 2'h0;
    endtask : pulse
    task automatic rd(input logic odd, input logic [15:0] want);
        @(negedge clock);
        {reg_read, reg_odd} = {1'b1, odd};
        @(negedge clock);
        reg_read = 1'b0;
        check(reg_rdata, want);
    endtask : rd
    task automatic wait_fetch(input logic lvl);
        for (int i = 0; i < 20 && fetch_req !== lvl; i++) @(negedge clock);
    endtask : wait_fetch
    initial begin
        repeat (3000) @(posedge clock);
        err_total++;
        final_report();
    end
    initial begin
        {reset_n, reg_write, reg_read, reg_odd, start, reg_wdata} = 21'h0;
        err_total = 0;
        checked = 0;
        irq_seen = 0;
        device_number = 8'h1F;
        iocc_dev_model_inst.chain_words = '{16'h0200, 16'h0002};
        iocc_dev_model_inst.fetch_delay = 3;
        repeat (6) @(negedge clock);
        reset_n = 1'b1;
        rd(1'b0, 16'h0000);
        rd(1'b1, 16'h0000);
        device_number = 8'hA5;
        @(negedge clock);
        device_number = 8'h40;
        pulse(1'b1, 1'b0, 1'b0, 16'h0040);
        pulse(1'b1, 1'b0, 1'b1, 16'h2002);
        rd(1'b1, 16'h2002);
        pulse(1'b0, 1'b1, 1'b0, 16'h0000);
        irq_seen = 0;
        repeat (2) iocc_dev_model_inst.send_byte(1'b0, 1'b0);
        @(negedge clock);
        check(count_done, 1'b1);
        check(byte_word_addr, 16'h0041);
        check(byte_lane, 1'b0);
        rd(1'b0, 16'h0041);
        iocc_dev_model_inst.end_op(1'b0, 8'h9F);
        rd(1'b0, 16'h9800);
        check(16'(irq_seen), 16'h0002);
        check(busy, 1'b0);
        // single byte then a chained doubleword served slowly
        pulse(1'b1, 1'b0, 1'b0, 16'h0100);
        pulse(1'b1, 1'b0, 1'b1, 16'h4001);
        pulse(1'b0, 1'b1, 1'b0, 16'h0000);
        irq_seen = 0;
        iocc_dev_model_inst.send_byte(1'b0, 1'b0);
        wait_fetch(1'b1);
        check(fetch_req, 1'b1);
        check(fetch_addr, 16'h0101);
        check(count_done, 1'b0);
        wait_fetch(1'b0);
        check(fetch_req, 1'b0);
        rd(1'b1, 16'h0002);
        rd(1'b0, 16'h0200);
        iocc_dev_model_inst.send_byte(1'b1, 1'b0);
        rd(1'b1, 16'h8001);
        iocc_dev_model_inst.end_op(1'b1, 8'h18);
        rd(1'b0, 16'h0800);
        check(16'(irq_seen), 16'h0000);
        // zero count is full length; a write while running must not land
        pulse(1'b1, 1'b0, 1'b0, 16'h0300);
        pulse(1'b1, 1'b0, 1'b1, 16'h0000);
        pulse(1'b0, 1'b1, 1'b0, 16'h0000);
        iocc_dev_model_inst.send_byte(1'b0, 1'b1);
        rd(1'b1, 16'h9FFF);
        check(byte_lane, 1'b1);
        pulse(1'b1, 1'b0, 1'b0, 16'hFFFF);
        rd(1'b0, 16'h0300);
        iocc_dev_model_inst.end_op(1'b0, 8'h88);
        rd(1'b0, 16'h8800);
        final_report();
    end
endmodule : tb_io_channel_control_chaining
